// [hdl/frt_pkg.sv]
`default_nettype none
// Shared constants for the free-running microsecond timer
package frt_pkg;

   // Bus geometry
   localparam int          FRT_ADDR_W       = 8;
   localparam int          FRT_DATA_W       = 32;

   // Register indices; the byte address is four times the index
   localparam logic [7:0]  FRT_IDX_LOW      = 8'h24;
   localparam logic [7:0]  FRT_IDX_HIGH     = 8'h25;
   localparam logic [7:0]  FRT_IDX_STAT     = 8'h26;
   localparam logic [7:0]  FRT_IDX_MASK     = 8'h27;
   localparam logic [7:0]  FRT_ADDR_LOW     = 8'(FRT_IDX_LOW * 4);
   localparam logic [7:0]  FRT_ADDR_HIGH    = 8'(FRT_IDX_HIGH * 4);
   localparam logic [7:0]  FRT_ADDR_STAT    = 8'(FRT_IDX_STAT * 4);
   localparam logic [7:0]  FRT_ADDR_MASK    = 8'(FRT_IDX_MASK * 4);

   // Counter geometry and field positions
   localparam int          FRT_CNT_W        = 12;
   localparam int          FRT_LOW_W        = 8;
   localparam int          FRT_HIGH_W       = 4;
   localparam int          FRT_EV_W         = 2;
   localparam int          FRT_EV_128       = 0;
   localparam int          FRT_EV_1024      = 1;

   // Interrupt periods in microseconds and the count bits that span them
   localparam int          FRT_P128_US      = 128;
   localparam int          FRT_P1024_US     = 1024;
   localparam int          FRT_P128_BITS    = $clog2(FRT_P128_US);
   localparam int          FRT_P1024_BITS   = $clog2(FRT_P1024_US);

   // Reset values
   localparam logic [11:0] FRT_COUNT_RST    = 12'h000;
   localparam logic [3:0]  FRT_HOLD_RST     = 4'h0;
   localparam logic [1:0]  FRT_STAT_RST     = 2'h0;
   localparam logic [1:0]  FRT_MASK_RST     = 2'h0;

   // Timing: 1 us tick from the 50 ns clock
   localparam int          FRT_CLK_NS       = 50;
   localparam int          FRT_TICK_NS      = 1000;
   localparam int          FRT_TICK_CYC     = FRT_TICK_NS / FRT_CLK_NS;
   localparam int          FRT_PRE_W        = $clog2(FRT_TICK_CYC);

   // Bus responses
   localparam logic [1:0]  FRT_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  FRT_RESP_SLVERR  = 2'h2;

endpackage
`default_nettype wire

// [hdl/frt_tick_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Carries the microsecond tick from the prescaler to the timer core
interface frt_tick_if;
   logic tick;

   modport src (output tick);
   modport dst (input  tick);
endinterface
`default_nettype wire

// [hdl/frt_tick.sv]
`timescale 1ns/100ps
`default_nettype none
// Prescaler: one-cycle pulse every microsecond
module frt_tick
   import frt_pkg::*;
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Tick out
   frt_tick_if.src   tick_bus
);

   typedef struct packed {
      logic [FRT_PRE_W-1:0] pre;
      logic                 tick;
   } frt_pre_state_t;

   frt_pre_state_t s;
   frt_pre_state_t next_s;

   // Divide by the tick length; pulse is registered to keep it clean
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.pre == FRT_PRE_W'(FRT_TICK_CYC - 1)) begin
         next_s.pre = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.pre = s.pre + FRT_PRE_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_bus.tick = s.tick;

   // Tick spacing
   tick_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.tick |=> !s.tick [*8])
      else $error("tick pulses too close");

endmodule
`default_nettype wire

// [hdl/frt_timer.sv]
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 12-bit counter increments once per microsecond tick, no software help.
// - Periodic interrupt event every 128 us derived from the count.
// - Second periodic interrupt event every 1.024 ms from the count.
// - Low byte read returns count[7:0] and captures count[11:8].
// - High byte read returns the captured nibble, not live bits.
// - Low byte register holds count bits 7..0, read-only.
// - High byte register holds captured bits 11..8, upper bits read zero.
module frt_timer
   import frt_pkg::*;
(
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Write address channel
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [FRT_ADDR_W-1:0] awaddr,
   // Write data channel
   input  wire logic                  wvalid,
   output logic                       wready,
   input  wire logic [FRT_DATA_W-1:0] wdata,
   input  wire logic [3:0]            wstrb,
   // Write response channel
   output logic                       bvalid,
   input  wire logic                  bready,
   output logic [1:0]                 bresp,
   // Read address channel
   input  wire logic                  arvalid,
   output logic                       arready,
   input  wire logic [FRT_ADDR_W-1:0] araddr,
   // Read data channel
   output logic                       rvalid,
   input  wire logic                  rready,
   output logic [FRT_DATA_W-1:0]      rdata,
   output logic [1:0]                 rresp,
   // Interrupt
   output logic                       irq
);

   // Whole state of the timer and its bus slave
   typedef struct packed {
      logic [FRT_CNT_W-1:0]  count;
      logic [FRT_HIGH_W-1:0] hold;
      logic [FRT_EV_W-1:0]   status;
      logic [FRT_EV_W-1:0]   mask;
      logic                  irq;
      logic                  awready;
      logic                  wready;
      logic                  aw_got;
      logic                  w_got;
      logic [FRT_ADDR_W-1:0] waddr;
      logic [FRT_DATA_W-1:0] wdata;
      logic [3:0]            wstrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [FRT_DATA_W-1:0] rdata;
      logic [1:0]            rresp;
   } frt_state_t;

   frt_state_t          s;
   frt_state_t          next_s;
   logic [FRT_EV_W-1:0] ev;
   logic                tick;

   // Microsecond prescaler kept apart so the core never counts raw clocks
   frt_tick_if tick_bus ();

   frt_tick u_tick (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .tick_bus (tick_bus)
   );

   assign tick = tick_bus.tick;

   // Period events fire on the tick that rolls the low bits over
   always_comb begin
      ev = '0;
      ev[FRT_EV_128]  = tick && (&s.count[FRT_P128_BITS-1:0]);
      ev[FRT_EV_1024] = tick && (&s.count[FRT_P1024_BITS-1:0]);
   end

   // Next-state logic for counter, registers and both bus directions
   always_comb begin
      next_s = s;

      // Free count; the 12-bit sum wraps to zero after 4095 by itself
      if (tick) begin
         next_s.count = s.count + 12'h001;
      end

      // Address and data may arrive in either order; each is held once taken
      if (s.awready && awvalid) begin
         next_s.aw_got = 1'b1;
         next_s.waddr  = awaddr;
      end
      if (s.wready && wvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end

      // Perform the write once both halves are in and no response waits
      if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = FRT_RESP_OKAY;
         if (next_s.waddr == FRT_ADDR_STAT) begin
            if (next_s.wstrb[0]) begin
               next_s.status = s.status & ~next_s.wdata[FRT_EV_W-1:0];
            end
         end else if (next_s.waddr == FRT_ADDR_MASK) begin
            if (next_s.wstrb[0]) begin
               next_s.mask = next_s.wdata[FRT_EV_W-1:0];
            end
         end else if (next_s.waddr == FRT_ADDR_LOW ||
                      next_s.waddr == FRT_ADDR_HIGH) begin
            // Timer bytes are read-only; the write is dropped quietly
            next_s.bresp = FRT_RESP_OKAY;
         end else begin
            next_s.bresp = FRT_RESP_SLVERR;
         end
      end

      // An event in the same cycle as its clear wins over the clear
      next_s.status = next_s.status | ev;

      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end

      // Reads snapshot the state of this cycle; counting goes on untouched
      if (s.arready && arvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = FRT_RESP_OKAY;
         next_s.rdata  = '0;
         if (araddr == FRT_ADDR_LOW) begin
            next_s.rdata = {24'h000000, s.count[FRT_LOW_W-1:0]};
            next_s.hold  = s.count[FRT_CNT_W-1:FRT_LOW_W];
         end else if (araddr == FRT_ADDR_HIGH) begin
            next_s.rdata = {28'h0000000, s.hold};
         end else if (araddr == FRT_ADDR_STAT) begin
            next_s.rdata = {30'h00000000, s.status};
         end else if (araddr == FRT_ADDR_MASK) begin
            next_s.rdata = {30'h00000000, s.mask};
         end else begin
            next_s.rresp = FRT_RESP_SLVERR;
         end
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // Readies come from flops; they drop while a transfer is pending
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready  = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;

      // Level interrupt, registered so the pin never glitches
      next_s.irq = |(next_s.status & next_s.mask);
   end

   // Single state register; reset clears count and holding nibble
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s        <= '0;
         s.count  <= FRT_COUNT_RST;
         s.hold   <= FRT_HOLD_RST;
         s.status <= FRT_STAT_RST;
         s.mask   <= FRT_MASK_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign awready = s.awready;
   assign wready  = s.wready;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign arready = s.arready;
   assign rvalid  = s.rvalid;
   assign rdata   = s.rdata;
   assign rresp   = s.rresp;
   assign irq     = s.irq;

   // Counter advances by exactly one per tick
   count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tick |=> s.count == 12'($past(s.count) + 12'h001))
      else $error("count did not step on tick");

   // Counter holds between ticks, even across register reads
   count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !tick |=> $stable(s.count))
      else $error("count moved without a tick");

   // Top of range wraps to zero
   count_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && s.count == 12'hfff) |=> s.count == 12'h000)
      else $error("count did not wrap");

   // 128 us event sets its status bit
   ev_short_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && s.count[6:0] == 7'h7f) |=> s.status[FRT_EV_128])
      else $error("128 us event lost");

   // 1.024 ms event sets its status bit and lands with the short one
   ev_long_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && s.count[9:0] == 10'h3ff)
         |=> s.status[FRT_EV_1024] && s.status[FRT_EV_128])
      else $error("1.024 ms event lost");

   // Long event never fires off its period
   ev_long_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!$past(s.status[FRT_EV_1024]) && s.status[FRT_EV_1024])
         |-> $past(s.count[9:0]) == 10'h3ff && $past(tick))
      else $error("1.024 ms event at wrong count");

   // Low byte read returns the live low bits and captures the nibble
   low_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.arready && arvalid && araddr == FRT_ADDR_LOW)
         |=> s.rvalid && s.rdata == {24'h000000, $past(s.count[7:0])}
             && s.hold == $past(s.count[11:8]))
      else $error("low byte read wrong");

   // High byte read returns the held nibble with zero upper bits
   high_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.arready && arvalid && araddr == FRT_ADDR_HIGH)
         |=> s.rvalid && s.rdata == {28'h0000000, $past(s.hold)})
      else $error("high byte read wrong");

   // Holding nibble changes only through a low byte read
   hold_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(s.arready && arvalid && araddr == FRT_ADDR_LOW) |=> $stable(s.hold))
      else $error("hold nibble changed without low read");

   // Low timer byte ignores writes
   ro_bytes_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s.awready && awvalid && awaddr == FRT_ADDR_LOW && !tick)
         |=> s.count == $past(s.count) || $past(tick, 1))
      else $error("write disturbed count");

   // A write response stands with a steady code until the master takes it
   bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.bvalid && !bready |=> s.bvalid && $stable(s.bresp))
      else $error("write response dropped early");

   // Read data stand unchanged until the master takes them
   rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.rvalid && !rready
         |=> s.rvalid && $stable(s.rdata) && $stable(s.rresp))
      else $error("read data dropped early");

   // No new write address while a response waits
   aw_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.bvalid |-> !s.awready)
      else $error("write address open during response");

   // No new write data while a response waits
   w_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.bvalid |-> !s.wready)
      else $error("write data open during response");

   // Only one read in flight
   ar_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.rvalid |-> !s.arready)
      else $error("read address open during read data");

   // Read address reopens the cycle after the data are taken
   ar_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.rvalid && rready |=> s.arready)
      else $error("read address did not reopen");

   // Write channels reopen the cycle after the response is taken
   aw_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.bvalid && bready |=> s.awready && s.wready)
      else $error("write channels did not reopen");

   // Both write halves in one cycle give a response one cycle later
   b_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.awready && awvalid && s.wready && wvalid |=> s.bvalid)
      else $error("write response late");

   // A taken read address gives data one cycle later
   r_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.arready && arvalid |=> s.rvalid)
      else $error("read data late");

   // Unmapped reads answer with an error
   rd_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.arready && arvalid && araddr[7:4] == 4'h0
         |=> s.rresp == FRT_RESP_SLVERR)
      else $error("unmapped read not refused");

   // Low byte read has nothing above bit 7
   low_zero_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s.arready && arvalid && araddr == FRT_ADDR_LOW
         |=> s.rdata[31:8] == 24'h000000)
      else $error("low byte read has upper bits");

   // Reserved bits of the high byte read as zero
   high_zero_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s.arready && arvalid && araddr == FRT_ADDR_HIGH
         |=> s.rdata[31:4] == 28'h0000000)
      else $error("high byte reserved bits set");

   // Short event never fires off its period
   short_once_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (!$past(s.status[FRT_EV_128]) && s.status[FRT_EV_128])
         |-> $past(s.count[6:0]) == 7'h7f && $past(tick))
      else $error("128 us event at wrong count");

   // Short status bit is sticky: it falls only with a completed write
   short_stick_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $fell(s.status[FRT_EV_128]) |-> $rose(s.bvalid))
      else $error("128 us status lost without a clear");

   // Long status bit is sticky as well
   long_stick_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $fell(s.status[FRT_EV_1024]) |-> $rose(s.bvalid))
      else $error("1.024 ms status lost without a clear");

   // Interrupt pin follows the unmasked status
   irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s.irq == |(s.status & s.mask))
      else $error("irq does not follow status and mask");

   // Ticks come exactly one microsecond apart
   tick_period_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      tick |-> ##20 tick)
      else $error("tick period wrong");

endmodule
`default_nettype wire

// [test/free_running_timer_12bit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module free_running_timer_12bit_tb
   import frt_pkg::*;
   ;
   logic        aclk    = 1'h0;
   logic        aresetn = 1'h0;
   logic        awvalid = 1'h0;
   logic        wvalid  = 1'h0;
   logic        bready  = 1'h0;
   logic        arvalid = 1'h0;
   logic        rready  = 1'h0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] lfsr    = 32'h7e0d6510;
   int          n_errors = 0;
   int          tests_run = 0;
   int          pc, mcnt, exp_cnt, hold;
   bit          tk;

   // Bench clock, 50 ns period
   always #25 aclk = ~aclk;

   frt_timer u_frt_timer (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .irq(irq)
   );

   // Reference count; the tick is registered, so counting lags one cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         pc <= 0;
         tk <= 0;
         mcnt <= 0;
         hold <= 0;
      end else begin
         pc <= (pc == FRT_TICK_CYC - 1) ? 0 : pc + 1;
         tk <= (pc == FRT_TICK_CYC - 1);
         if (tk)
            mcnt <= (mcnt + 1) % 4096;
      end
      if (arvalid && arready) begin
         exp_cnt <= mcnt;
         if (araddr == FRT_ADDR_LOW)
            hold <= mcnt / 256;
      end
   end

   function automatic logic [31:0] nxt();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      bit ad;
      bit wd;
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      ad = 0;
      wd = 0;
      for (n = 0; n < 100 && !(ad && wd); n++) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ad = 1;
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            wd = 1;
            wvalid <= 1'h0;
         end
      end
      n = 0;
      while (!bvalid && n < 100) begin
         @(posedge aclk);
         n++;
      end
      if (!bvalid)
         n_errors++;
      check("bresp", 32'(bresp), 32'(er));
      bready <= 1'h0;
   endtask

   // Read with a random stall before rready; rvalid must stand meanwhile
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      n = 0;
      do @(posedge aclk); while (!arready && ++n < 100);
      if (!arready)
         n_errors++;
      arvalid <= 1'h0;
      repeat (nxt() % 3) @(posedge aclk);
      rready <= 1'h1;
      n = 0;
      do @(posedge aclk); while (!rvalid && ++n < 100);
      if (!rvalid)
         n_errors++;
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check("rdata", d, e);
      check("rresp", 32'(r), 32'(er));
   endtask

   // Low then high, with a gap so the live nibble may move on
   task automatic pair(input int gap);
      logic [31:0] d;
      logic [1:0]  r;
      rd(FRT_ADDR_LOW, d, r);
      check("low", d, 32'(exp_cnt % 256));
      repeat (gap) @(posedge aclk);
      rd(FRT_ADDR_HIGH, d, r);
      check("high", d, 32'(hold));
   endtask

   task automatic wait_cnt(input int v);
      while (mcnt != v) @(posedge aclk);
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      pair(0);
      rc(FRT_ADDR_STAT, 32'h0, FRT_RESP_OKAY);
      rc(FRT_ADDR_MASK, 32'h0, FRT_RESP_OKAY);
      check("irq", 32'(irq), 32'h0);
      rc(8'h00, 32'h0, FRT_RESP_SLVERR);
      wr(8'ha0, nxt(), FRT_RESP_SLVERR);
      wr(FRT_ADDR_LOW, nxt(), FRT_RESP_OKAY);
      wr(FRT_ADDR_HIGH, nxt(), FRT_RESP_OKAY);
      for (int i = 0; i < 8; i++)
         pair(nxt() % 64);
      wr(FRT_ADDR_MASK, 32'h3, FRT_RESP_OKAY);
      rc(FRT_ADDR_MASK, 32'h3, FRT_RESP_OKAY);
      wait_cnt(12'h070);
      rc(FRT_ADDR_STAT, 32'h0, FRT_RESP_OKAY);
      wait_cnt(12'h088);
      rc(FRT_ADDR_STAT, 32'h1, FRT_RESP_OKAY);
      check("irq", 32'(irq), 32'h1);
      wr(FRT_ADDR_STAT, 32'h1, FRT_RESP_OKAY);
      rc(FRT_ADDR_STAT, 32'h0, FRT_RESP_OKAY);
      check("irq", 32'(irq), 32'h0);
      // Only the slow event is unmasked from here
      wr(FRT_ADDR_MASK, 32'h2, FRT_RESP_OKAY);
      wait_cnt(12'h0f0);
      rc(FRT_ADDR_STAT, 32'h0, FRT_RESP_OKAY);
      wait_cnt(12'h108);
      rc(FRT_ADDR_STAT, 32'h1, FRT_RESP_OKAY);
      check("irq", 32'(irq), 32'h0);
      wait_cnt(12'h3f0);
      rc(FRT_ADDR_STAT, 32'h1, FRT_RESP_OKAY);
      wr(FRT_ADDR_STAT, 32'h3, FRT_RESP_OKAY);
      wait_cnt(12'h408);
      rc(FRT_ADDR_STAT, 32'h3, FRT_RESP_OKAY);
      check("irq", 32'(irq), 32'h1);
      wr(FRT_ADDR_STAT, 32'h2, FRT_RESP_OKAY);
      rc(FRT_ADDR_STAT, 32'h1, FRT_RESP_OKAY);
      check("irq", 32'(irq), 32'h0);
      // Snapshot across a nibble change, then across the wrap
      wait_cnt(12'h4fe);
      pair(200);
      wait_cnt(12'hffe);
      pair(200);
      pair(0);
      // Reset in mid-run clears count, holding nibble, status and mask
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rc(FRT_ADDR_HIGH, 32'h0, FRT_RESP_OKAY);
      rc(FRT_ADDR_STAT, 32'h0, FRT_RESP_OKAY);
      rc(FRT_ADDR_MASK, 32'h0, FRT_RESP_OKAY);
      pair(0);
      close_out();
   end

   // Watchdog: the run needs about 82000 cycles
   initial begin
      repeat (90000) @(posedge aclk);
      n_errors++;
      close_out();
   end
endmodule
`default_nettype wire
